// ===== dtc_pkg.sv
// Purpose: Shared constants for the dual timer/counter block
// Assumes: APB word registers, byte address is four times the register index
// Notes:   Mode codes, field positions, prescale divisors and register indices
package dtc_pkg;
   // Register indices (byte address = index * 4)
   localparam logic [9:0] IDX_CTRL      = 10'h088;
   localparam logic [9:0] IDX_MODE      = 10'h089;
   localparam logic [9:0] IDX_T0_LOW    = 10'h08A;
   localparam logic [9:0] IDX_T1_LOW    = 10'h08B;
   localparam logic [9:0] IDX_T0_HIGH   = 10'h08C;
   localparam logic [9:0] IDX_T1_HIGH   = 10'h08D;
   localparam logic [9:0] IDX_CLK_SEL   = 10'h08E;
   localparam logic [9:0] IDX_IRQ_CFG   = 10'h08F;

   // Reset values
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [3:0] RST_NIBBLE    = 4'h0;

   // timer_clock_select fields
   localparam int CK_THIRD_HIGH = 7;
   localparam int CK_THIRD_LOW  = 6;
   localparam int CK_FOURTH_HI  = 5;
   localparam int CK_FOURTH_LO  = 4;
   localparam int CK_SECOND     = 3;
   localparam int CK_FIRST      = 2;
   localparam int CK_SCALE_HI   = 1;
   localparam int CK_SCALE_LO   = 0;

   // timer_control_reg fields (bits 3:0 read as zero)
   localparam int CT_SECOND_FLAG = 7;
   localparam int CT_SECOND_RUN  = 6;
   localparam int CT_FIRST_FLAG  = 5;
   localparam int CT_FIRST_RUN   = 4;

   // timer_mode_reg fields
   localparam int MD_SECOND_GATE = 7;
   localparam int MD_SECOND_CSEL = 6;
   localparam int MD_SECOND_HI   = 5;
   localparam int MD_SECOND_LO   = 4;
   localparam int MD_FIRST_GATE  = 3;
   localparam int MD_FIRST_CSEL  = 2;
   localparam int MD_FIRST_HI    = 1;
   localparam int MD_FIRST_LO    = 0;

   // Interrupt/polarity configuration fields
   localparam int CF_FIRST_IE    = 0;
   localparam int CF_SECOND_IE   = 1;
   localparam int CF_POL_A       = 2;
   localparam int CF_POL_B       = 3;

   // Mode field codes
   localparam logic [1:0] MODE_13BIT  = 2'h0;
   localparam logic [1:0] MODE_16BIT  = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT  = 2'h3;

   // Prescale field codes and divisors
   localparam logic [1:0] SCALE_DIV12 = 2'h0;
   localparam logic [1:0] SCALE_DIV4  = 2'h1;
   localparam logic [1:0] SCALE_DIV48 = 2'h2;
   localparam logic [1:0] SCALE_EXT8  = 2'h3;
   localparam logic [5:0] DIV12_LAST  = 6'h0B;
   localparam logic [5:0] DIV4_LAST   = 6'h03;
   localparam logic [5:0] DIV48_LAST  = 6'h2F;
   localparam logic [5:0] EXT8_LAST   = 6'h07;
   localparam logic [5:0] CNT_ZERO    = 6'h00;
   localparam logic [5:0] CNT_ONE     = 6'h01;

   // Count limits
   localparam logic [12:0] CNT13_MAX  = 13'h1FFF;
   localparam logic [15:0] CNT16_MAX  = 16'hFFFF;
   localparam logic [7:0]  CNT8_MAX   = 8'hFF;
   localparam logic [7:0]  BYTE_ONE   = 8'h01;
   localparam logic [12:0] CNT13_ONE  = 13'h0001;
   localparam logic [15:0] CNT16_ONE  = 16'h0001;
endpackage : dtc_pkg

// ===== dtc_edge_sync.sv
// Purpose: Two-flop synchroniser with one-cycle edge pulse
// Assumes: Input level holds for at least two clk cycles
// Notes:   FALL selects high-to-low detection, otherwise low-to-high
`timescale 1ns/100ps
module dtc_edge_sync #(
   parameter bit FALL = 1'b1
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic asyncIn,
   output logic      edgePulse
);
   logic stage1Ff;
   logic stage2Ff;
   logic stage3Ff;

   // Synchroniser chain; only stage2 reads stage1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1Ff <= 1'b0;
         stage2Ff <= 1'b0;
         stage3Ff <= 1'b0;
      end else begin
         stage1Ff <= asyncIn;
         stage2Ff <= stage1Ff;
         stage3Ff <= stage2Ff;
      end
   end

   // Edge compare on settled stages only
   assign edgePulse = FALL ? (stage3Ff & ~stage2Ff) : (~stage3Ff & stage2Ff);
endmodule : dtc_edge_sync

// ===== dtc_prescaler.sv
// Purpose: Shared prescale tick for both timers
// Assumes: extRise is a one-cycle pulse per external oscillator cycle
// Notes:   Counter restarts when the prescale field changes
`timescale 1ns/100ps
module dtc_prescaler
   import dtc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] scaleSel,
   input  wire logic       extRise,
   output logic            preTick
);
   logic [5:0] cntFf;
   logic [5:0] nxt_cnt;
   logic [1:0] selFf;
   logic [5:0] lastVal;
   logic       advance;

   // Divisor pick; external source only advances on its own edges
   always_comb begin
      lastVal = DIV12_LAST;
      advance = 1'b1;
      case (scaleSel)
         SCALE_DIV12: lastVal = DIV12_LAST;
         SCALE_DIV4:  lastVal = DIV4_LAST;
         SCALE_DIV48: lastVal = DIV48_LAST;
         SCALE_EXT8: begin
            lastVal = EXT8_LAST;
            advance = extRise;
         end
         default: lastVal = DIV12_LAST;
      endcase
      preTick = advance && (cntFf == lastVal);  // [R05]
      if (selFf != scaleSel) begin
         nxt_cnt = CNT_ZERO;  // Avoid a stale count past the new limit
      end else if (preTick) begin
         nxt_cnt = CNT_ZERO;
      end else if (advance) begin
         nxt_cnt = cntFf + CNT_ONE;
      end else begin
         nxt_cnt = cntFf;
      end
   end

   // Count registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cntFf <= CNT_ZERO;
         selFf <= SCALE_DIV12;
      end else begin
         cntFf <= nxt_cnt;
         selFf <= scaleSel;
      end
   end
endmodule : dtc_prescaler

// ===== dtc_timer.sv
// Purpose: Dual counter/timer with clock select, APB register access
// Assumes: Interrupt and event inputs synchronous except the synchronised pins
// Notes:   No wait state on any APB access
//
// Functional notes
// [R01] Third timer bytes: bit set means system clock
// [R02] Fourth timer bytes: bit set means system clock
// [R03] Second timer: bit3 picks sysclk or prescale
// [R04] First timer: bit2 picks sysclk or prescale
// [R05] Prescale: /12, /4, /48, ext/8
// [R06] Sixteen-bit count as two byte registers
// [R07] 13-bit: high byte plus five low bits
// [R08] 13-bit wrap sets overflow flag
// [R09] Counter select counts event pin falling edges
// [R10] Run needs run bit and gate condition
// [R11] Run bit never clears the count
// [R12] Second timer mirrors first with own bits
// [R13] Mode 1 counts all sixteen bits
// [R14] Mode 2 reloads low from high
// [R15] Software preloads low byte before mode 2
// [R16] Split mode low byte uses first controls
// [R17] Split high byte: second run, second flag
// [R18] Second timer in split: no events, no flag
// [R19] Second timer in split runs unless mode 3
// [R20] Interrupt forwarded only when enabled
// [R21] Flags: hardware set, software or vector clear
// [R22] Mode field: 13, 16, reload, split
// [R23] Event levels held two clocks minimum
// [R24] Pins and oscillator synchronised, edge pulses
`timescale 1ns/100ps
module dtc_timer
   import dtc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        firstEventPin,
   input  wire logic        secondEventPin,
   input  wire logic        extOscClk,
   input  wire logic        extIrqAInput,
   input  wire logic        extIrqBInput,
   input  wire logic        firstIrqAck,
   input  wire logic        secondIrqAck,
   input  wire logic        thirdExtClkTick,
   input  wire logic        thirdSplitMode,
   input  wire logic        fourthExtClkTick,
   input  wire logic        fourthSplitMode,
   output logic             firstTimerIrq,
   output logic             secondTimerIrq,
   output logic             secondOverflowPulse,
   output logic             thirdLowTick,
   output logic             thirdHighTick,
   output logic             fourthLowTick,
   output logic             fourthHighTick
);
   // Step one timer; returns {overflow, high, low}
   function automatic logic [16:0] dtc_step(input logic [1:0] mode, input logic [7:0] lo,
                                            input logic [7:0] hi, input logic en);
      logic [12:0] c13;
      logic [15:0] c16;
      c13 = {hi, lo[4:0]};
      c16 = {hi, lo};
      dtc_step = {1'b0, hi, lo};
      if (en) begin
         case (mode)
            MODE_13BIT: begin
               c13 = c13 + CNT13_ONE;  // [R07]
               dtc_step = {({hi, lo[4:0]} == CNT13_MAX), c13[12:5], lo[7:5], c13[4:0]};  // [R08]
            end
            MODE_16BIT: begin
               c16 = c16 + CNT16_ONE;
               dtc_step = {({hi, lo} == CNT16_MAX), c16};  // [R13]
            end
            MODE_RELOAD: begin
               if (lo == CNT8_MAX) begin
                  dtc_step = {1'b1, hi, hi};  // [R14]
               end else begin
                  dtc_step = {1'b0, hi, lo + BYTE_ONE};
               end
            end
            MODE_SPLIT: begin
               dtc_step = {(lo == CNT8_MAX), hi, lo + BYTE_ONE};  // [R16]
            end
            default: dtc_step = {1'b0, hi, lo};
         endcase
      end
   endfunction : dtc_step

   // Register state
   logic [7:0]  clkSelFf;
   logic [7:0]  nxt_clkSel;
   logic [3:0]  ctrlFf;
   logic [3:0]  nxt_ctrl;
   logic [7:0]  modeFf;
   logic [7:0]  nxt_mode;
   logic [3:0]  cfgFf;
   logic [3:0]  nxt_cfg;
   logic [7:0]  t0LowFf;
   logic [7:0]  nxt_t0Low;
   logic [7:0]  t0HighFf;
   logic [7:0]  nxt_t0High;
   logic [7:0]  t1LowFf;
   logic [7:0]  nxt_t1Low;
   logic [7:0]  t1HighFf;
   logic [7:0]  nxt_t1High;
   logic [31:0] prdataFf;
   logic [31:0] nxt_prdata;
   logic        preadyFf;
   logic        nxt_pready;
   logic        pslverrFf;
   logic        nxt_pslverr;
   logic [7:0]  outsFf;
   logic [7:0]  nxt_outs;

   // Helper nets
   logic        evFirst;
   logic        evSecond;
   logic        extRise;
   logic        preTick;
   logic [9:0]  regIdx;
   logic        wrEn;
   logic        mapped;
   logic [7:0]  wByte;
   logic        irqAActive;
   logic        irqBActive;
   logic        splitMode;
   logic        firstEn;
   logic        highSplitEn;
   logic        secondRun;
   logic        secondTick;
   logic        secondEn;
   logic [16:0] firstRes;
   logic [16:0] secondRes;
   logic [8:0]  highSplit;
   logic        firstSet;
   logic        secondSet;

   // Event pins and oscillator brought into clk domain
   dtc_edge_sync #(.FALL(1'b1)) uEvFirst (  // [R24] [R23]
      .clk       (clk),
      .rst_n     (rst_n),
      .asyncIn   (firstEventPin),
      .edgePulse (evFirst)
   );
   dtc_edge_sync #(.FALL(1'b1)) uEvSecond (  // [R24]
      .clk       (clk),
      .rst_n     (rst_n),
      .asyncIn   (secondEventPin),
      .edgePulse (evSecond)
   );
   dtc_edge_sync #(.FALL(1'b0)) uExtOsc (  // [R24]
      .clk       (clk),
      .rst_n     (rst_n),
      .asyncIn   (extOscClk),
      .edgePulse (extRise)
   );

   // Shared prescaler; oscillator must run below a quarter of clk
   dtc_prescaler uPrescale (
      .clk      (clk),
      .rst_n    (rst_n),
      .scaleSel (clkSelFf[CK_SCALE_HI:CK_SCALE_LO]),
      .extRise  (extRise),
      .preTick  (preTick)
   );

   // APB decode
   assign regIdx = paddr[11:2];
   assign wByte  = pwdata[7:0];
   assign wrEn   = psel & penable & pwrite & preadyFf & ~pslverrFf;

   // Run and clock enables
   always_comb begin
      irqAActive  = ~(extIrqAInput ^ cfgFf[CF_POL_A]);  // [R10]
      irqBActive  = ~(extIrqBInput ^ cfgFf[CF_POL_B]);  // [R12]
      splitMode   = (modeFf[MD_FIRST_HI:MD_FIRST_LO] == MODE_SPLIT);  // [R22]
      // First timer: event edges or sysclk/prescale
      firstEn     = ctrlFf[CT_FIRST_RUN] & (~modeFf[MD_FIRST_GATE] | irqAActive)  // [R10]
                    & (modeFf[MD_FIRST_CSEL] ? evFirst  // [R09]
                       : (clkSelFf[CK_FIRST] | preTick));  // [R04]
      // Split high byte: timer only, second run bit, first clock select
      highSplitEn = splitMode & ctrlFf[CT_SECOND_RUN] & (clkSelFf[CK_FIRST] | preTick);  // [R17]
      // Second timer: mode 3 stops it; in split its mode alone runs it
      if (splitMode) begin
         secondRun = (modeFf[MD_SECOND_HI:MD_SECOND_LO] != MODE_SPLIT);  // [R19]
      end else begin
         secondRun = ctrlFf[CT_SECOND_RUN] & (~modeFf[MD_SECOND_GATE] | irqBActive)  // [R12]
                     & (modeFf[MD_SECOND_HI:MD_SECOND_LO] != MODE_SPLIT);
      end
      secondTick  = (modeFf[MD_SECOND_CSEL] & ~splitMode) ? evSecond  // [R18]
                    : (clkSelFf[CK_SECOND] | preTick);  // [R03]
      secondEn    = secondRun & secondTick;
      firstRes    = dtc_step(modeFf[MD_FIRST_HI:MD_FIRST_LO], t0LowFf, t0HighFf, firstEn);
      secondRes   = dtc_step(modeFf[MD_SECOND_HI:MD_SECOND_LO], t1LowFf, t1HighFf, secondEn);
      highSplit   = {(t0HighFf == CNT8_MAX), t0HighFf + BYTE_ONE};
      firstSet    = firstRes[16];
      secondSet   = splitMode ? (highSplitEn & highSplit[8]) : secondRes[16];  // [R17]
   end

   // Register file and counters next state
   always_comb begin
      nxt_clkSel = clkSelFf;
      nxt_mode   = modeFf;
      nxt_cfg    = cfgFf;
      // Counting never depends on run-bit edges, so setting run keeps the count
      nxt_t0Low  = firstRes[7:0];  // [R11]
      nxt_t0High = firstRes[15:8];
      nxt_t1Low  = secondRes[7:0];  // [R12]
      nxt_t1High = secondRes[15:8];
      if (highSplitEn) begin
         nxt_t0High = highSplit[7:0];  // [R17]
      end
      nxt_ctrl   = ctrlFf;
      // Software writes win over counting in the same cycle
      if (wrEn) begin
         case (regIdx)
            IDX_CLK_SEL: nxt_clkSel = wByte;
            IDX_MODE:    nxt_mode   = wByte;
            IDX_IRQ_CFG: nxt_cfg    = wByte[3:0];
            IDX_CTRL:    nxt_ctrl   = wByte[7:4];
            IDX_T0_LOW:  nxt_t0Low  = wByte;  // [R06]
            IDX_T0_HIGH: nxt_t0High = wByte;
            IDX_T1_LOW:  nxt_t1Low  = wByte;
            IDX_T1_HIGH: nxt_t1High = wByte;
            default:     nxt_ctrl   = ctrlFf;
         endcase
      end
      // Vector acknowledge clears; hardware set wins over any clear
      if (firstIrqAck) begin
         nxt_ctrl[CT_FIRST_FLAG-4] = 1'b0;  // [R21]
      end
      if (secondIrqAck) begin
         nxt_ctrl[CT_SECOND_FLAG-4] = 1'b0;  // [R21]
      end
      if (firstSet) begin
         nxt_ctrl[CT_FIRST_FLAG-4] = 1'b1;  // [R08]
      end
      if (secondSet) begin
         nxt_ctrl[CT_SECOND_FLAG-4] = 1'b1;  // [R18]
      end
   end

   // APB answer: captured in setup, presented through the access phase
   always_comb begin
      mapped      = 1'b1;
      nxt_prdata  = 32'h0000_0000;
      case (regIdx)
         IDX_CLK_SEL: nxt_prdata[7:0] = clkSelFf;
         IDX_MODE:    nxt_prdata[7:0] = modeFf;
         IDX_IRQ_CFG: nxt_prdata[3:0] = cfgFf;
         IDX_CTRL:    nxt_prdata[7:4] = ctrlFf;
         IDX_T0_LOW:  nxt_prdata[7:0] = t0LowFf;
         IDX_T0_HIGH: nxt_prdata[7:0] = t0HighFf;
         IDX_T1_LOW:  nxt_prdata[7:0] = t1LowFf;
         IDX_T1_HIGH: nxt_prdata[7:0] = t1HighFf;
         default:     mapped = 1'b0;
      endcase
      nxt_pready  = psel & ~penable;
      nxt_pslverr = psel & ~penable & ~mapped;
      if (!(psel & ~penable)) begin
         nxt_prdata = prdataFf;  // Hold data through access phase
      end
   end

   // Registered side outputs
   always_comb begin
      nxt_outs    = 8'h00;
      nxt_outs[0] = nxt_ctrl[CT_FIRST_FLAG-4] & cfgFf[CF_FIRST_IE];  // [R20]
      nxt_outs[1] = nxt_ctrl[CT_SECOND_FLAG-4] & cfgFf[CF_SECOND_IE];  // [R20]
      nxt_outs[2] = secondRes[16];  // [R18]
      nxt_outs[3] = clkSelFf[CK_THIRD_LOW] | thirdExtClkTick;  // [R01]
      nxt_outs[4] = thirdSplitMode & (clkSelFf[CK_THIRD_HIGH] | thirdExtClkTick);  // [R01]
      nxt_outs[5] = clkSelFf[CK_FOURTH_LO] | fourthExtClkTick;  // [R02]
      nxt_outs[6] = fourthSplitMode & (clkSelFf[CK_FOURTH_HI] | fourthExtClkTick);  // [R02]
   end

   // State registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clkSelFf  <= RST_BYTE;
         modeFf    <= RST_BYTE;
         cfgFf     <= RST_NIBBLE;
         ctrlFf    <= RST_NIBBLE;
         t0LowFf   <= RST_BYTE;
         t0HighFf  <= RST_BYTE;
         t1LowFf   <= RST_BYTE;
         t1HighFf  <= RST_BYTE;
         prdataFf  <= 32'h0000_0000;
         preadyFf  <= 1'b0;
         pslverrFf <= 1'b0;
         outsFf    <= RST_BYTE;
      end else begin
         clkSelFf  <= nxt_clkSel;
         modeFf    <= nxt_mode;
         cfgFf     <= nxt_cfg;
         ctrlFf    <= nxt_ctrl;
         t0LowFf   <= nxt_t0Low;
         t0HighFf  <= nxt_t0High;
         t1LowFf   <= nxt_t1Low;
         t1HighFf  <= nxt_t1High;
         prdataFf  <= nxt_prdata;
         preadyFf  <= nxt_pready;
         pslverrFf <= nxt_pslverr;
         outsFf    <= nxt_outs;
      end
   end

   // Outputs straight from flops
   assign prdata              = prdataFf;
   assign pready              = preadyFf;
   assign pslverr             = pslverrFf;
   assign firstTimerIrq       = outsFf[0];
   assign secondTimerIrq      = outsFf[1];
   assign secondOverflowPulse = outsFf[2];
   assign thirdLowTick        = outsFf[3];
   assign thirdHighTick       = outsFf[4];
   assign fourthLowTick       = outsFf[5];
   assign fourthHighTick      = outsFf[6];
endmodule : dtc_timer

// ===== dtc_timer_monitor.sv
// Purpose: Port-level checks for the dual timer block
// Assumes: One clock domain, async active-low reset
// Notes:   Tick checks cover the pass-through clock selects only
`timescale 1ns/100ps
module dtc_timer_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic thirdExtClkTick,
   input wire logic thirdSplitMode,
   input wire logic fourthExtClkTick,
   input wire logic fourthSplitMode,
   input wire logic thirdLowTick,
   input wire logic thirdHighTick,
   input wire logic fourthLowTick,
   input wire logic fourthHighTick
);
   // One domain, so shared clocking and reset gate
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Bus answer timing
   property p_setup_ready; psel && !penable |=> pready; endproperty
   a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
   property p_ready_access; pready |-> psel && penable; endproperty
   a_ready_access: assert property (p_ready_access) else $error("ready outside access");
   property p_ready_single; pready |=> !pready; endproperty
   a_ready_single: assert property (p_ready_single) else $error("ready held too long");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   // Clock-select pass-through, one registered stage
   property p_third_low; thirdExtClkTick |=> thirdLowTick; endproperty
   a_third_low: assert property (p_third_low) else $error("third low tick lost");
   property p_third_high; !thirdSplitMode |=> !thirdHighTick; endproperty
   a_third_high: assert property (p_third_high) else $error("third high tick outside split");
   property p_fourth_low; fourthExtClkTick |=> fourthLowTick; endproperty
   a_fourth_low: assert property (p_fourth_low) else $error("fourth low tick lost");
   property p_fourth_high; !fourthSplitMode |=> !fourthHighTick; endproperty
   a_fourth_high: assert property (p_fourth_high) else $error("fourth high tick outside split");
endmodule : dtc_timer_monitor

bind dtc_timer dtc_timer_monitor u_mon (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .thirdExtClkTick(thirdExtClkTick), .thirdSplitMode(thirdSplitMode),
   .fourthExtClkTick(fourthExtClkTick), .fourthSplitMode(fourthSplitMode), .thirdLowTick(thirdLowTick),
   .thirdHighTick(thirdHighTick), .fourthLowTick(fourthLowTick), .fourthHighTick(fourthHighTick));

// ===== tb_dtc_timer.sv
// Purpose: Self-checking bench for the dual timer block
// Assumes: No wait state on any bus access, reads checked from a queue
// Notes:   Gate input parks counts so reads are exact
`timescale 1ns/100ps
module tb_dtc_timer
   import dtc_pkg::*;
;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        ev0, ev1, osc, irqA, irqB, ack0, ack1, t3x, t3s, t4x, t4s;
   logic        irq0, irq1, ovf1, t3l, t3h, t4l, t4h;
   logic [32:0] expQ[$];
   int          error_cnt, cmp_count, ovfSeen;
   logic [7:0]  lf, st;

   dtc_timer u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .firstEventPin(ev0), .secondEventPin(ev1), .extOscClk(osc), .extIrqAInput(irqA),
      .extIrqBInput(irqB), .firstIrqAck(ack0), .secondIrqAck(ack1), .thirdExtClkTick(t3x),
      .thirdSplitMode(t3s), .fourthExtClkTick(t4x), .fourthSplitMode(t4s), .firstTimerIrq(irq0),
      .secondTimerIrq(irq1), .secondOverflowPulse(ovf1), .thirdLowTick(t3l), .thirdHighTick(t3h),
      .fourthLowTick(t4l), .fourthHighTick(t4h));

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr

   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("errors=%0d compares=%0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   // Bus transfer; request held until ready seen, reads queue their expectation
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd, input logic [32:0] exp);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      if (!wr) expQ.push_back(exp);
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) error_cnt++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 33'h000000000);
   endtask : wr

   task automatic rd(input logic [9:0] idx, input logic [7:0] d);
      apb(1'b0, idx, 8'h00, {25'h0000000, d});
   endtask : rd

   // Read results compared as they appear
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
         check({pslverr, prdata}, expQ.pop_front());
      end
   end

   // Second-timer overflow pulses seen at the pin
   always @(posedge clk) begin
      if (ovf1 === 1'b1) ovfSeen++;
   end

   // Watchdog
   initial begin
      #400000;
      error_cnt++;
      give_verdict();
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, ev0, osc, ack0, ack1, t3x, t3s, t4x, t4s} = '0;
      {ev1, irqA, irqB} = 3'h7;
      rst_n = 1'b0;
      lf = 8'h54;
      error_cnt = 0;
      cmp_count = 0;
      ovfSeen = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Reset values, unmapped index refused
      rd(IDX_CLK_SEL, 8'h00);
      rd(IDX_CTRL, 8'h00);
      rd(IDX_MODE, 8'h00);
      apb(1'b0, 10'h090, 8'h00, {1'b1, 32'h00000000});
      // Random clock selects and pass-through ticks
      repeat (6) begin
         lf = lfsr(lf);
         wr(IDX_CLK_SEL, lf);
         rd(IDX_CLK_SEL, lf);
         t3x <= lf[2];
         t4x <= lf[3];
         t3s <= lf[0];
         t4s <= lf[1];
         repeat (2) @(posedge clk);
         check({t3l, t3h}, {lf[6] | lf[2], lf[0] & (lf[7] | lf[2])});
         check({t4l, t4h}, {lf[4] | lf[3], lf[1] & (lf[5] | lf[3])});
      end
      // 13-bit then 16-bit wrap; gate parks the count before and after
      wr(IDX_CLK_SEL, 8'h04);
      for (int m = 0; m < 2; m++) begin
         st = m ? 8'hFF : 8'h1F;
         wr(IDX_IRQ_CFG, m ? 8'h00 : 8'h01);
         wr(IDX_MODE, 8'h08 | m[7:0]);
         wr(IDX_T0_LOW, st);
         wr(IDX_T0_HIGH, 8'hFF);
         wr(IDX_CTRL, 8'h10);
         rd(IDX_T0_LOW, st);
         irqA <= 1'b0;
         repeat (6) @(posedge clk);
         irqA <= 1'b1;
         repeat (2) @(posedge clk);
         rd(IDX_T0_HIGH, 8'h00);
         rd(IDX_CTRL, 8'h30);
         check(irq0, !m);
         if (m == 0) begin
            ack0 <= 1'b1;
            @(posedge clk);
            ack0 <= 1'b0;
         end else wr(IDX_CTRL, 8'h10);
         rd(IDX_CTRL, 8'h10);
      end
      // Prescaled ticks over a 48-cycle gate window; tick phase cannot skew the count
      for (int s = 0; s < 3; s++) begin
         wr(IDX_CLK_SEL, s[7:0]);
         wr(IDX_T0_LOW, 8'h00);
         wr(IDX_T0_HIGH, 8'h00);
         irqA <= 1'b0;
         repeat (48) @(posedge clk);
         irqA <= 1'b1;
         repeat (2) @(posedge clk);
         rd(IDX_T0_LOW, (s == 0) ? 8'h04 : ((s == 1) ? 8'h0C : 8'h01));
      end
      // Auto-reload keeps low at the reload value, high untouched
      wr(IDX_CLK_SEL, 8'h04);
      wr(IDX_T0_HIGH, 8'hFF);
      wr(IDX_T0_LOW, 8'hFF);
      wr(IDX_MODE, 8'h02);
      repeat (10) @(posedge clk);
      rd(IDX_T0_LOW, 8'hFF);
      rd(IDX_T0_HIGH, 8'hFF);
      rd(IDX_CTRL, 8'h30);
      // Second timer counts pin falls through its overflow, clock select ignored
      wr(IDX_CTRL, 8'h00);
      wr(IDX_CLK_SEL, 8'h08);
      wr(IDX_MODE, 8'h50);
      wr(IDX_T1_LOW, 8'hFE);
      wr(IDX_T1_HIGH, 8'hFF);
      wr(IDX_CTRL, 8'h40);
      repeat (2) begin
         ev1 <= 1'b0;
         repeat (3) @(posedge clk);
         ev1 <= 1'b1;
         repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      rd(IDX_T1_LOW, 8'h00);
      rd(IDX_T1_HIGH, 8'h00);
      rd(IDX_CTRL, 8'hC0);
      check(ovfSeen, 1);
      // Split mode: high byte runs on second run bit, sets second flag
      wr(IDX_CTRL, 8'h00);
      wr(IDX_T0_HIGH, 8'hFF);
      wr(IDX_T0_LOW, 8'h55);
      wr(IDX_MODE, 8'h13);
      wr(IDX_CLK_SEL, 8'h04);
      wr(IDX_IRQ_CFG, 8'h02);
      wr(IDX_CTRL, 8'h40);
      repeat (10) @(posedge clk);
      rd(IDX_CTRL, 8'hC0);
      rd(IDX_T0_LOW, 8'h55);
      check(irq1, 1'b1);
      repeat (3) @(posedge clk);
      give_verdict();
   end
endmodule : tb_dtc_timer
